// file: design/pcix_pin_reset_ctrl.sv
// Secondary bus pin reset control for two bridges with an AHB-Lite register slave
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module pcix_pin_reset_ctrl #(
	parameter int GNT_W = 5,
	parameter int NUM_BRIDGES = 2
) (
	// Clock, reset and clock enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Device level resets and power
	input wire logic dev_reset_n,
	input wire logic power_good,
	// AHB-Lite slave port
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Per-bridge secondary reset and capability inputs
	input wire logic [1:0] sec_reset_n,
	input wire logic [1:0] pcix_cap,
	// Grant pin input sides, index 0 is bridge A
	input wire logic [1:0][4:0] gnt_i,
	// Hot plug latch clock sources from the hot plug controllers
	input wire logic [1:0] hotplug_serial_out_latch_clock,
	// Default bus strap, bridge A only
	input wire logic bridge_a_default_bus_strap,
	// Pin drive state per bridge
	output pin_ctrl_pkg::pins_t [1:0] pins,
	// Default bus configuration bit
	output logic default_bus_select
);

	// Refuse sizes the fixed pin map cannot serve
	if (GNT_W != pin_ctrl_pkg::GNT_W || NUM_BRIDGES != pin_ctrl_pkg::NUM_BRIDGES) begin : g_bad_size
		$error("Only five grants on each of two bridges are supported");
	end

	// Control register
	logic [pin_ctrl_pkg::CTRL_W-1:0] ctrl_q;
	// Captured frequency straps per bridge
	logic [1:0][pin_ctrl_pkg::FREQ_W-1:0] freq_q;
	// Captured bus mode per bridge
	logic [1:0] pcix_mode_q;
	// Previous secondary reset level, for release detection
	logic [1:0] sec_reset_prev_q;
	// Single slot mode per bridge from the pin logic
	logic [1:0] single_slot;
	// Configuration carriers
	pin_ctrl_pkg::bridge_cfg_t [1:0] cfg;
	// Data phase bookkeeping
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	// Address phase decode
	logic addr_valid;
	logic [31:0] read_value;
	logic [31:0] status_value;
	// Bus answer registers
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic default_bus_q;

	// A new single transfer is accepted when the bus is ready
	assign addr_valid = hsel && htrans == pin_ctrl_pkg::HTRANS_NONSEQ && hready;

	// Outputs straight from their registers
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign default_bus_select = default_bus_q;

	// Status word built from captured straps and live state
	always_comb begin
		status_value = '0;
		status_value[pin_ctrl_pkg::STAT_FREQ_A +: 2] = freq_q[0];
		status_value[pin_ctrl_pkg::STAT_FREQ_B +: 2] = freq_q[1];
		status_value[pin_ctrl_pkg::STAT_PCIX_A] = pcix_mode_q[0];
		status_value[pin_ctrl_pkg::STAT_PCIX_B] = pcix_mode_q[1];
		status_value[pin_ctrl_pkg::STAT_SS_A] = single_slot[0];
		status_value[pin_ctrl_pkg::STAT_SS_B] = single_slot[1];
		status_value[pin_ctrl_pkg::STAT_PGOOD] = power_good;
		status_value[pin_ctrl_pkg::STAT_STRAP] = bridge_a_default_bus_strap;
	end

	// Read mux, unmapped offsets read as zero
	always_comb begin
		read_value = '0;
		if (haddr == pin_ctrl_pkg::CTRL_OFS) begin
			read_value[pin_ctrl_pkg::CTRL_W-1:0] = ctrl_q;
		end else if (haddr == pin_ctrl_pkg::STATUS_OFS) begin
			read_value = status_value;
		end
	end

	// Split the control register into per-bridge carriers
	always_comb begin
		cfg[0].hp_en = ctrl_q[pin_ctrl_pkg::CTRL_HP_EN_A];
		cfg[0].sss_n = ctrl_q[pin_ctrl_pkg::CTRL_SSS_N_A];
		cfg[0].slot_powered = ctrl_q[pin_ctrl_pkg::CTRL_PWR_A];
		cfg[1].hp_en = ctrl_q[pin_ctrl_pkg::CTRL_HP_EN_B];
		cfg[1].sss_n = ctrl_q[pin_ctrl_pkg::CTRL_SSS_N_B];
		cfg[1].slot_powered = ctrl_q[pin_ctrl_pkg::CTRL_PWR_B];
		// Both bridges share the initialization pattern setting
		cfg[0].devsel_drive = ctrl_q[pin_ctrl_pkg::CTRL_DEVSEL_DRV];
		cfg[0].devsel_level = ctrl_q[pin_ctrl_pkg::CTRL_DEVSEL_LVL];
		cfg[1].devsel_drive = ctrl_q[pin_ctrl_pkg::CTRL_DEVSEL_DRV];
		cfg[1].devsel_level = ctrl_q[pin_ctrl_pkg::CTRL_DEVSEL_LVL];
	end

	// Bus answer: ready from one enabled cycle after reset, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'h0;
			hresp_q <= 1'h0;
		end else if (ce) begin
			// Zero wait states, so ready rises one cycle after reset
			hreadyout_q <= 1'h1;
			hresp_q <= 1'h0;
		end
	end

	// Read data latched at the address phase, shown in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (ce) begin
			if (addr_valid && !hwrite) begin
				hrdata_q <= read_value;
			end
		end
	end

	// Write address held until the data phase brings hwdata
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'h0;
			wr_addr_q <= '0;
		end else if (ce) begin
			if (addr_valid) begin
				wr_pend_q <= hwrite;
				wr_addr_q <= haddr;
			end else if (hready) begin
				wr_pend_q <= 1'h0;
			end
		end
	end

	// Control register; straps reload CTRL_SSS_N_B and CTRL_DEF_BUS while power is not good
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= pin_ctrl_pkg::CTRL_RST;
		end else if (ce) begin
			if (wr_pend_q && wr_addr_q == pin_ctrl_pkg::CTRL_OFS) begin
				ctrl_q <= hwdata[pin_ctrl_pkg::CTRL_W-1:0];
			end
			// Strap load wins over a software write in the same cycle
			if (!power_good) begin
				ctrl_q[pin_ctrl_pkg::CTRL_SSS_N_B] <= gnt_i[1][pin_ctrl_pkg::GNT_SSS_STRAP];
				ctrl_q[pin_ctrl_pkg::CTRL_DEF_BUS] <= bridge_a_default_bus_strap;
			end
		end
	end

	// Default bus bit mirrored to its own output flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			default_bus_q <= 1'h0;
		end else if (ce) begin
			default_bus_q <= ctrl_q[pin_ctrl_pkg::CTRL_DEF_BUS];
		end
	end

	// Frequency straps sampled while the grants are still inputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			freq_q <= '0;
		end else if (ce) begin
			if (!power_good) begin
				// Last sample before power good rises is kept
				freq_q[0] <= gnt_i[0][4:3];
				freq_q[1] <= gnt_i[1][4:3];
			end
		end
	end

	// Secondary reset history for release detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Idle level of the pin, so no false release right after reset
			sec_reset_prev_q <= '1;
		end else if (ce) begin
			sec_reset_prev_q <= sec_reset_n;
		end
	end

	// Bus mode captured only at the secondary reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pcix_mode_q <= '0;
		end else if (ce) begin
			for (int b = 0; b < 2; b++) begin
				// Capability pin is ignored at all other times
				if (sec_reset_n[b] && !sec_reset_prev_q[b]) begin
					pcix_mode_q[b] <= pcix_cap[b];
				end
			end
		end
	end

	// One pin drive block per bridge
	for (genvar b = 0; b < 2; b++) begin : g_bridge
		bridge_pin_drive u_drive (
			.hclk(hclk),
			.hresetn(hresetn),
			.ce(ce),
			.dev_reset_n(dev_reset_n),
			.power_good(power_good),
			.sec_reset_n(sec_reset_n[b]),
			.cfg(cfg[b]),
			.hotplug_serial_out_latch_clock(hotplug_serial_out_latch_clock[b]),
			.pins_q(pins[b]),
			.single_slot(single_slot[b])
		);
	end

endmodule : pcix_pin_reset_ctrl

// file: design/pin_ctrl_pkg.sv
// Shared constants, field layouts and carrier types for the bridge pin reset control
package pin_ctrl_pkg;

	// Bridge and pin group sizes
	localparam int NUM_BRIDGES = 2;
	localparam int GNT_W = 5;
	localparam int CTL_W = 7;
	localparam int FREQ_W = 2;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;

	// Control register fields
	localparam int CTRL_HP_EN_A = 0;
	localparam int CTRL_HP_EN_B = 1;
	localparam int CTRL_SSS_N_A = 2;
	localparam int CTRL_SSS_N_B = 3;
	localparam int CTRL_DEF_BUS = 4;
	localparam int CTRL_PWR_A = 5;
	localparam int CTRL_PWR_B = 6;
	localparam int CTRL_DEVSEL_DRV = 7;
	localparam int CTRL_DEVSEL_LVL = 8;
	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RST = 9'h00c;

	// Status register fields
	localparam int STAT_FREQ_A = 0;
	localparam int STAT_FREQ_B = 2;
	localparam int STAT_PCIX_A = 4;
	localparam int STAT_PCIX_B = 5;
	localparam int STAT_SS_A = 6;
	localparam int STAT_SS_B = 7;
	localparam int STAT_PGOOD = 8;
	localparam int STAT_STRAP = 9;

	// Control pin positions inside the slot control group
	localparam int CTL_FRAME = 0;
	localparam int CTL_IRDY = 1;
	localparam int CTL_DEVSEL = 2;
	localparam int CTL_ACK64 = 3;
	localparam int CTL_PERR = 4;
	localparam int CTL_PAR = 5;
	localparam int CTL_PAR64 = 6;

	// Grant that carries the strapped single slot default on bridge B
	localparam int GNT_SSS_STRAP = 2;
	localparam int GNT_LATCH_CLK = 4;

	// AHB transfer type for a new single transfer
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// Per-bridge pin drive state, enables active low
	typedef struct packed {
		logic ad_oe_n;
		logic [CTL_W-1:0] ctl_o;
		logic [CTL_W-1:0] ctl_oe_n;
		logic [GNT_W-1:0] gnt_o;
		logic [GNT_W-1:0] gnt_oe_n;
	} pins_t;

	// Power-on pin state: nothing driven, grants released
	localparam pins_t PINS_RST = '{ad_oe_n: 1'h1, ctl_o: 7'h00, ctl_oe_n: 7'h7f, gnt_o: 5'h1f, gnt_oe_n: 5'h1f};

	// Per-bridge configuration handed to the pin logic
	typedef struct packed {
		logic hp_en;
		logic sss_n;
		logic slot_powered;
		logic devsel_drive;
		logic devsel_level;
	} bridge_cfg_t;

endpackage : pin_ctrl_pkg

// file: design/bridge_pin_drive.sv
// Pin state selection for the secondary bus pins of one bridge
`timescale 1ns/10ps
module bridge_pin_drive (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Device resets and power
	input wire logic dev_reset_n,
	input wire logic power_good,
	input wire logic sec_reset_n,
	// Configuration and hot plug clock source
	input wire pin_ctrl_pkg::bridge_cfg_t cfg,
	input wire logic hotplug_serial_out_latch_clock,
	// Registered pin state
	output pin_ctrl_pkg::pins_t pins_q,
	output logic single_slot
);

	// Next pin state
	pin_ctrl_pkg::pins_t pins_d;

	// Low select bit with hot plug enabled means one slot without isolation switches
	assign single_slot = cfg.hp_en & ~cfg.sss_n;

	// Pin state from mode and reset sources
	always_comb begin
		pins_d = pin_ctrl_pkg::PINS_RST;
		// Address-data parked low once out of reset
		pins_d.ad_oe_n = 1'h0;
		if (single_slot && (!dev_reset_n || !cfg.slot_powered)) begin
			// Unpowered slot sees every listed pin low
			pins_d.ctl_o = '0;
			pins_d.ctl_oe_n = '0;
		end else if (!single_slot && (!sec_reset_n || !dev_reset_n)) begin
			// Slot pins follow the secondary reset in normal mode
			pins_d.ctl_oe_n[pin_ctrl_pkg::CTL_PAR] = 1'h0;
			pins_d.ctl_oe_n[pin_ctrl_pkg::CTL_PAR64] = 1'h0;
			// Device select shaped for the initialization pattern
			pins_d.ctl_oe_n[pin_ctrl_pkg::CTL_DEVSEL] = ~cfg.devsel_drive;
			pins_d.ctl_o[pin_ctrl_pkg::CTL_DEVSEL] = cfg.devsel_level;
		end
		// Grants ignore both resets; single slot mode and the latch clock shape them
		pins_d.gnt_o = single_slot ? 5'h1e : 5'h1f;
		if (cfg.hp_en) begin
			pins_d.gnt_o[pin_ctrl_pkg::GNT_LATCH_CLK] = hotplug_serial_out_latch_clock;
		end
		// Grants are strap inputs until power is good
		pins_d.gnt_oe_n = power_good ? 5'h00 : 5'h1f;
	end

	// Pin state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins_q <= pin_ctrl_pkg::PINS_RST;
		end else if (ce) begin
			pins_q <= pins_d;
		end
	end

endmodule : bridge_pin_drive

// file: dv/pin_ctrl_assertions.sv
// Port checker for the bridge pin reset control
`timescale 1ns/10ps
module pin_ctrl_assertions (
	// Clock and resets
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic dev_reset_n,
	input wire logic power_good,
	input wire logic [1:0] sec_reset_n,
	// Sources
	input wire logic [1:0] hotplug_serial_out_latch_clock,
	input wire logic bridge_a_default_bus_strap,
	// Pin state and config mirror
	input wire pin_ctrl_pkg::pins_t [1:0] pins,
	input wire logic default_bus_select
);
	// One domain, so clock and reset stated once
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Grant direction follows power good
	AST_GNT_IN: assert property (ce && !power_good
		|=> {pins[1].gnt_oe_n, pins[0].gnt_oe_n} == 10'h3ff) else $error("grants driven early");
	AST_GNT_OUT: assert property (ce && power_good
		|=> {pins[1].gnt_oe_n, pins[0].gnt_oe_n} == 10'h000) else $error("grants not driven");
	// Middle grants never pulled low
	AST_GNT_HI: assert property ({pins[1].gnt_o[3:1], pins[0].gnt_o[3:1]} == 6'h3f)
		else $error("grant 1-3 low");
	// Grant 0 low marks single slot, so grant 4 carries the latch clock
	AST_LATCH: assert property (!pins[0].gnt_o[0]
		|-> pins[0].gnt_o[4] == $past(hotplug_serial_out_latch_clock[0])) else $error("latch clock lost");
	// Normal mode: secondary or main reset pulls parity low, frame stays released
	AST_PAR_RST: assert property (ce && pins[0].gnt_o[0] && !sec_reset_n[0]
		|=> !pins[0].ctl_oe_n[pin_ctrl_pkg::CTL_PAR] && !pins[0].ctl_o[pin_ctrl_pkg::CTL_PAR]) else $error("par free");
	AST_KEEP_FRAME: assert property (ce && pins[0].gnt_o[0] && !sec_reset_n[0] && dev_reset_n
		|=> pins[0].ctl_oe_n[pin_ctrl_pkg::CTL_FRAME]) else $error("frame driven");
	AST_DEV_RST: assert property (ce && pins[1].gnt_o[0] && !dev_reset_n
		|=> !pins[1].ctl_oe_n[pin_ctrl_pkg::CTL_PAR64]) else $error("par64 free");
	// Single slot: main reset drives all control pins low
	AST_SS_RST: assert property (ce && !pins[0].gnt_o[0] && !dev_reset_n
		|=> pins[0].ctl_oe_n == 7'h00 && pins[0].ctl_o == 7'h00) else $error("slot pins free");
	// Strap reaches the mirror two edges later
	AST_DEFBUS: assert property (ce && !power_good
		|=> ##1 default_bus_select == $past(bridge_a_default_bus_strap, 2)) else $error("strap lost");
	// Main scenarios reached
	COV_SS: cover property (!pins[0].gnt_o[0] && !dev_reset_n);
	COV_SEC: cover property (!sec_reset_n[0] ##1 sec_reset_n[0]);
	COV_PG: cover property (!power_good ##1 power_good);
endmodule : pin_ctrl_assertions

bind pcix_pin_reset_ctrl pin_ctrl_assertions chk_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
	.dev_reset_n(dev_reset_n), .power_good(power_good), .sec_reset_n(sec_reset_n),
	.hotplug_serial_out_latch_clock(hotplug_serial_out_latch_clock),
	.bridge_a_default_bus_strap(bridge_a_default_bus_strap), .pins(pins), .default_bus_select(default_bus_select));

// file: dv/slot_board_model.sv
// Board side of the grant pins: strap resistors and wire levels
`timescale 1ns/10ps
module slot_board_model (
	// Device drive state
	input wire pin_ctrl_pkg::pins_t [1:0] pins,
	// Strap resistor levels per bridge
	input wire logic [1:0][4:0] strap,
	// Resolved wire levels
	output logic [1:0][4:0] gnt_i
);
	// Released wire falls to its resistor, never holds the old value
	always_comb begin
		for (int b = 0; b < 2; b++) begin
			for (int k = 0; k < 5; k++) begin
				gnt_i[b][k] = pins[b].gnt_oe_n[k] ? strap[b][k] : pins[b].gnt_o[k];
			end
		end
	end
endmodule : slot_board_model

// file: dv/pcix_bridge_pin_reset_control_tb.sv
// Self-checking bench for the bridge pin reset control
`timescale 1ns/10ps
module pcix_bridge_pin_reset_control_tb;
	// Design and board signals
	logic hclk, hresetn, ce, dev_reset_n, power_good, hsel, hwrite, hready, hreadyout, hresp;
	logic bridge_a_default_bus_strap, default_bus_select;
	logic [7:0] haddr;
	logic [1:0] htrans, sec_reset_n, pcix_cap, hotplug_serial_out_latch_clock;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata;
	logic [1:0][4:0] gnt_i, strap;
	pin_ctrl_pkg::pins_t [1:0] pins;
	int fails, total_checks;
	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	pcix_pin_reset_ctrl pcix_pin_reset_ctrl_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .dev_reset_n(dev_reset_n),
		.power_good(power_good), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sec_reset_n(sec_reset_n), .pcix_cap(pcix_cap), .gnt_i(gnt_i),
		.hotplug_serial_out_latch_clock(hotplug_serial_out_latch_clock),
		.bridge_a_default_bus_strap(bridge_a_default_bus_strap), .pins(pins), .default_bus_select(default_bus_select));
	slot_board_model slot_board_model_i (.pins(pins), .strap(strap), .gnt_i(gnt_i));
	// 100 MHz clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// Verdict and exit
	task automatic end_sim();
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Let edges pass, then look after they settle
	task automatic tick(input int k);
		repeat (k) @(posedge hclk);
		#1;
	endtask : tick
	// Bounded wait for ready at a rising edge
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			fails++;
			end_sim();
		end
	endtask : rdy
	// One AHB-Lite single word transfer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		htrans <= pin_ctrl_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		r = hrdata;
		// Slave answer must always be OKAY
		chk(32'(hresp), 32'h0);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x & m, e);
	endtask : rd
	// Straps sampled while power is bad, grants driven after
	task automatic s_power();
		tick(3);
		chk(32'({pins[1].gnt_oe_n, pins[0].gnt_oe_n}), 32'h3ff);
		@(posedge hclk);
		power_good <= 1'b1;
		tick(3);
		chk(32'({pins[1].gnt_oe_n, pins[0].gnt_oe_n}), 32'h0);
		chk(32'({pins[1].gnt_o, pins[0].gnt_o}), 32'h3ff);
		chk(32'(default_bus_select), 32'h1);
		rd(8'h04, 32'h30f, 32'h306);
		rd(8'h00, 32'h1ff, 32'h014);
	endtask : s_power
	// Normal mode secondary reset, device select and mode capture
	task automatic s_normal();
		wr(8'h00, 32'h094);
		@(posedge hclk);
		sec_reset_n <= 2'h2;
		pcix_cap <= 2'h1;
		tick(2);
		chk(32'({pins[1].ctl_oe_n, pins[0].ctl_oe_n}), 32'h3f9b);
		chk(32'(pins[0].ctl_o), 32'h0);
		wr(8'h00, 32'h194);
		tick(2);
		chk(32'(pins[0].ctl_o), 32'h04);
		@(posedge hclk);
		sec_reset_n <= 2'h3;
		@(posedge hclk);
		pcix_cap <= 2'h0;
		tick(2);
		chk(32'(pins[0].ctl_oe_n), 32'h7f);
		rd(8'h04, 32'h30, 32'h10);
	endtask : s_normal
	// Single slot on A, hot plug with isolation on B
	task automatic s_single();
		wr(8'h00, 32'h01b);
		tick(2);
		chk(32'({pins[1].gnt_o, pins[0].gnt_o}), 32'h3ee);
		chk(32'({pins[0].ad_oe_n, pins[0].ctl_oe_n, pins[0].ctl_o}), 32'h0);
		rd(8'h04, 32'hc0, 32'h40);
		@(posedge hclk);
		hotplug_serial_out_latch_clock <= 2'h1;
		tick(2);
		chk(32'({pins[1].gnt_o, pins[0].gnt_o}), 32'h1fe);
		wr(8'h00, 32'h03b);
		tick(2);
		chk(32'(pins[0].ctl_oe_n), 32'h7f);
		@(posedge hclk);
		dev_reset_n <= 1'b0;
		tick(2);
		chk(32'({pins[1].ctl_oe_n, pins[0].ctl_oe_n}), 32'hf80);
		@(posedge hclk);
		dev_reset_n <= 1'b1;
		tick(2);
		chk(32'(pins[1].ctl_oe_n), 32'h7f);
	endtask : s_single
	// Unmapped offset reads zero and ignores writes
	task automatic s_regs();
		rd(8'h08, 32'hffffffff, 32'h0);
		wr(8'h08, 32'h1ff);
		rd(8'h00, 32'h1ff, 32'h03b);
	endtask : s_regs
	// Main sequence
	initial begin
		hresetn = 1'b0;
		ce = 1'b1;
		dev_reset_n = 1'b1;
		power_good = 1'b0;
		hsel = 1'b1;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		sec_reset_n = 2'h3;
		pcix_cap = 2'h0;
		hotplug_serial_out_latch_clock = 2'h2;
		bridge_a_default_bus_strap = 1'b1;
		strap = {5'h0b, 5'h17};
		fails = 0;
		total_checks = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		s_power();
		s_normal();
		s_single();
		s_regs();
		end_sim();
	end
endmodule : pcix_bridge_pin_reset_control_tb
